// ==== common/ivl_pkg.sv ====
// Constants and carrier types for the input volume and level control block.
package ivl_pkg;
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h09;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h0c;
  localparam logic [7:0] GAIN_RESET = 8'he1;
  localparam logic [7:0] GAIN_MIN = 8'h01;
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Sample periods of the shortest waiting period and shortest timeout (128/fs).
  localparam logic [14:0] WAIT_BASE = 15'h0080;
  localparam logic [10:0] ZC_BASE = 11'h080;
  localparam logic [10:0] ZC_ONE = 11'h001;
  localparam logic [14:0] WAIT_ONE = 15'h0001;
  localparam logic [7:0] STEP_ONE = 8'h01;
  localparam logic [3:0] FAST_SHIFT_BASE = 4'h2;
  localparam logic [1:0] FAST_NA = 2'h3;
  // Full-scale fractions of a 16-bit magnitude, index is the threshold select.
  localparam logic [3:0][15:0] DET_LVL = {16'h301b, 16'h4027, 16'h4fd5, 16'h5ffd};
  localparam logic [3:0][15:0] RST_LVL = {16'h2027, 16'h301b, 16'h4027, 16'h4fd5};
  localparam logic [15:0] IMPULSE_LVL = 16'h7f00;
  localparam logic [7:0] INIT_SAMPLES = 8'h40;
  localparam logic [7:0] INIT_ONE = 8'h01;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_INIT = 2'b01,
    ST_MANUAL = 2'b11,
    ST_ALC = 2'b10
  } ivl_mode_t;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
    logic valid;
  } ivl_sample_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ivl_wr_t;

  typedef struct packed {
    logic level_control_enable;
    logic [1:0] limiter_threshold_sel;
    logic [1:0] limiter_step_sel;
    logic [2:0] recovery_wait_sel;
    logic [1:0] zero_cross_timeout_sel;
    logic [1:0] recovery_step_sel;
    logic [1:0] fast_recovery_speed_sel;
    logic [7:0] recovery_ceiling_gain;
    logic limiter_zero_cross_disable;
  } ivl_cfg_t;

  typedef struct packed {
    ivl_mode_t mode;
    logic [7:0] left_gain_code;
    logic [7:0] right_gain_code;
    logic [7:0] gain_l;
    logic [7:0] gain_r;
    logic pend_l;
    logic pend_r;
    logic att_pend;
    logic rec_pend;
    logic fast;
    logic sign_l;
    logic sign_r;
    logic [10:0] zc_cnt;
    logic [14:0] wait_cnt;
    logic [7:0] init_cnt;
    logic [7:0] rd_data;
    logic active;
  } ivl_state_t;

  localparam ivl_state_t STATE_RST = '{
    mode: ST_OFF,
    left_gain_code: GAIN_RESET,
    right_gain_code: GAIN_RESET,
    gain_l: GAIN_RESET,
    gain_r: GAIN_RESET,
    default: '0
  };
endpackage

// ==== rtl/ivl_volume_ctrl.sv ====
// Input digital volume with automatic level control, limiter and recovery.
`timescale 1ns/1ns
`default_nettype none
module ivl_volume_ctrl
  import ivl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire ivl_wr_t wr_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire ivl_cfg_t cfg_i,
  input wire logic left_adc_power_i,
  input wire logic right_adc_power_i,
  input wire ivl_sample_t level_i,
  output logic [7:0] left_gain_o,
  output logic [7:0] right_gain_o,
  output logic level_control_active_o,
  output logic fast_recovery_o
);
  ivl_state_t q;
  ivl_state_t d;
  logic tick;
  logic powered;
  logic [15:0] abs_l;
  logic [15:0] abs_r;
  logic [15:0] peak;
  logic over;
  logic below;
  logic impulse;
  logic zc_l;
  logic zc_r;
  logic timeout;
  logic [10:0] zto_len;
  logic [14:0] wait_base_len;
  logic [14:0] wait_len;
  logic [1:0] fast_sel;
  logic [7:0] lim_step;
  logic [7:0] rec_step;
  logic wr_left_new;
  logic wr_right_new;

  assign tick = level_i.valid;
  assign powered = left_adc_power_i | right_adc_power_i;
  assign abs_l = level_i.left[15] ? (~level_i.left + 16'h0001) : level_i.left;
  assign abs_r = level_i.right[15] ? (~level_i.right + 16'h0001) : level_i.right;
  assign peak = (abs_l > abs_r) ? abs_l : abs_r;
  assign over = peak >= DET_LVL[cfg_i.limiter_threshold_sel];
  assign below = peak < RST_LVL[cfg_i.limiter_threshold_sel];
  assign impulse = tick && (peak >= IMPULSE_LVL);
  assign zc_l = tick && (level_i.left[15] != q.sign_l);
  assign zc_r = tick && (level_i.right[15] != q.sign_r);
  assign zto_len = ZC_BASE << cfg_i.zero_cross_timeout_sel;
  assign timeout = tick && (q.zc_cnt >= (zto_len - ZC_ONE));
  assign wait_base_len = WAIT_BASE << cfg_i.recovery_wait_sel;
  // The not-available speed code falls back to the slowest fast rate.
  assign fast_sel = (cfg_i.fast_recovery_speed_sel == FAST_NA) ? 2'h0 :
                    cfg_i.fast_recovery_speed_sel;
  assign wait_len = q.fast ? (wait_base_len >> (FAST_SHIFT_BASE + 4'(fast_sel))) :
                    wait_base_len;
  assign lim_step = STEP_ONE << cfg_i.limiter_step_sel;
  assign rec_step = {6'h00, cfg_i.recovery_step_sel} + STEP_ONE;
  // Writes only count when they change the stored code.
  assign wr_left_new = wr_i.en && (wr_i.addr == ADDR_LEFT_GAIN) &&
                       (wr_i.data != q.left_gain_code);
  assign wr_right_new = wr_i.en && (wr_i.addr == ADDR_RIGHT_GAIN) &&
                        (wr_i.data != q.right_gain_code);

  always_comb begin
    logic [7:0] g;
    g = q.gain_l;
    d = q;
    if (tick) begin
      d.sign_l = level_i.left[15];
      d.sign_r = level_i.right[15];
      d.zc_cnt = timeout ? '0 : q.zc_cnt + ZC_ONE;
    end
    // Settings are sampled live, so the host must keep them steady while active.
    if (q.mode != ST_ALC) begin
      if (wr_left_new) begin
        d.left_gain_code = wr_i.data;
        d.pend_l = 1'b1;
        d.zc_cnt = '0;
      end
      if (wr_right_new) begin
        d.right_gain_code = wr_i.data;
        d.pend_r = 1'b1;
        d.zc_cnt = '0;
      end
    end
    unique case (q.mode)
      ST_OFF: begin
        if (powered) begin
          d.mode = ST_INIT;
          d.init_cnt = '0;
        end
      end
      ST_INIT: begin
        if (!powered) begin
          d.mode = ST_OFF;
        end else if (tick) begin
          d.init_cnt = q.init_cnt + INIT_ONE;
          if (q.init_cnt == (INIT_SAMPLES - INIT_ONE)) begin
            d.gain_l = d.left_gain_code;
            d.gain_r = cfg_i.level_control_enable ? d.left_gain_code : d.right_gain_code;
            d.pend_l = 1'b0;
            d.pend_r = 1'b0;
            d.wait_cnt = '0;
            d.mode = cfg_i.level_control_enable ? ST_ALC : ST_MANUAL;
          end
        end
      end
      ST_MANUAL: begin
        if (q.pend_l && (zc_l || timeout)) begin
          d.gain_l = q.left_gain_code;
          d.pend_l = wr_left_new; // A write in this cycle stays pending.
        end
        if (q.pend_r && (zc_r || timeout)) begin
          d.gain_r = q.right_gain_code;
          d.pend_r = wr_right_new; // A write in this cycle stays pending.
        end
        if (!powered) begin
          d.mode = ST_OFF;
        end else if (cfg_i.level_control_enable) begin
          d.mode = ST_ALC;
          d.gain_l = q.left_gain_code;
          d.gain_r = q.left_gain_code;
          d.pend_l = 1'b0;
          d.pend_r = 1'b0;
          d.att_pend = 1'b0;
          d.rec_pend = 1'b0;
          d.fast = 1'b0;
          d.wait_cnt = '0;
        end
      end
      ST_ALC: begin
        if (!powered) begin
          d.mode = ST_OFF;
        end else if (!cfg_i.level_control_enable) begin
          // The gains go back to the stored codes at a zero crossing or timeout; re-enabling too soon cuts this short.
          d.mode = ST_MANUAL;
          d.pend_l = 1'b1;
          d.pend_r = 1'b1;
          d.zc_cnt = '0;
        end else if (tick) begin
          if (over) begin
            d.att_pend = 1'b1;
            d.rec_pend = 1'b0;
            d.wait_cnt = '0;
          end else if (!below) begin
            d.wait_cnt = '0;
          end else if (q.wait_cnt >= (wait_len - WAIT_ONE)) begin
            d.rec_pend = 1'b1;
            d.wait_cnt = '0;
          end else begin
            d.wait_cnt = q.wait_cnt + WAIT_ONE;
          end
          if (impulse) begin
            d.fast = 1'b1;
          end
          if ((q.att_pend || over) &&
              (cfg_i.limiter_zero_cross_disable || zc_l || zc_r || timeout)) begin
            if (cfg_i.limiter_zero_cross_disable) begin
              g = (q.gain_l <= STEP_ONE) ? GAIN_MIN : q.gain_l - STEP_ONE;
            end else begin
              g = (q.gain_l <= lim_step) ? GAIN_MIN : q.gain_l - lim_step;
            end
            // A muted code stays muted; the limiter never lifts it.
            if (q.gain_l == GAIN_MUTE) begin
              g = GAIN_MUTE;
            end
            d.att_pend = 1'b0;
          end else if (q.rec_pend && (zc_l || zc_r || timeout)) begin
            if (q.gain_l >= cfg_i.recovery_ceiling_gain) begin
              g = q.gain_l;
            end else if ((cfg_i.recovery_ceiling_gain - q.gain_l) <= rec_step) begin
              g = cfg_i.recovery_ceiling_gain;
            end else begin
              g = q.gain_l + rec_step;
            end
            d.rec_pend = below && (q.wait_cnt >= (wait_len - WAIT_ONE)); // A new expiry wins.
            d.fast = 1'b0;
          end
          d.gain_l = g;
          d.gain_r = g;
        end
      end
    endcase
    if (rd_addr_i == ADDR_LEFT_GAIN) begin
      d.rd_data = d.left_gain_code;
    end else if (rd_addr_i == ADDR_RIGHT_GAIN) begin
      d.rd_data = d.right_gain_code;
    end else begin
      d.rd_data = READ_ZERO;
    end
    d.active = (d.mode == ST_ALC);
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign rd_data_o = q.rd_data;
  assign left_gain_o = q.gain_l;
  assign right_gain_o = q.gain_r;
  assign level_control_active_o = q.active;
  assign fast_recovery_o = q.fast;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_alc_hold;
    q.mode == ST_ALC && powered && cfg_i.level_control_enable && tick;
  endsequence
  sequence s_manual_hold;
    q.mode == ST_MANUAL && powered && !cfg_i.level_control_enable;
  endsequence

  property p_band_reset;
    s_alc_hold and (!over && !below) |=> q.wait_cnt == '0;
  endproperty
  a_band_reset: assert property (p_band_reset) else $error("wait timer kept in band");
  property p_wait_runs;
    s_alc_hold and (below && q.wait_cnt < (wait_len - WAIT_ONE))
      |=> q.wait_cnt == $past(q.wait_cnt) + WAIT_ONE;
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("wait timer not running");
  property p_ceiling;
    q.mode == ST_ALC && $past(q.mode) == ST_ALC && q.gain_l > $past(q.gain_l)
      |-> q.gain_l <= cfg_i.recovery_ceiling_gain;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("recovery above ceiling");
  property p_shared;
    q.mode == ST_ALC |-> q.gain_l == q.gain_r;
  endproperty
  a_shared: assert property (p_shared) else $error("channel gains differ when active");
  property p_ignored;
    q.mode == ST_ALC && wr_i.en |=> q.left_gain_code == $past(q.left_gain_code)
      && q.right_gain_code == $past(q.right_gain_code);
  endproperty
  a_ignored: assert property (p_ignored) else $error("gain write taken when active");
  property p_restart;
    s_manual_hold and wr_left_new
      |=> q.zc_cnt == '0 && q.pend_l && q.left_gain_code == $past(wr_i.data);
  endproperty
  a_restart: assert property (p_restart) else $error("differing write not restarting");
  property p_same_write;
    s_manual_hold and (wr_i.en && !wr_left_new && !wr_right_new && tick && !timeout)
      |=> q.zc_cnt == $past(q.zc_cnt) + ZC_ONE;
  endproperty
  a_same_write: assert property (p_same_write) else $error("same write restarted");
  property p_start;
    q.mode == ST_MANUAL && powered && cfg_i.level_control_enable
      |=> q.mode == ST_ALC && q.gain_l == $past(q.left_gain_code)
      && q.gain_r == $past(q.left_gain_code);
  endproperty
  a_start: assert property (p_start) else $error("left gain not common start");
  property p_limit_fast;
    s_alc_hold and (over && cfg_i.limiter_zero_cross_disable && q.gain_l > lim_step)
      |=> q.gain_l == $past(q.gain_l) - STEP_ONE;
  endproperty
  a_limit_fast: assert property (p_limit_fast) else $error("limiter step wrong");
  property p_manual_apply;
    s_manual_hold and (q.pend_l && timeout) |=> q.gain_l == $past(q.left_gain_code);
  endproperty
  a_manual_apply: assert property (p_manual_apply) else $error("manual gain not applied");
endmodule
`default_nettype wire

// ==== sim/ivl_adc_model.sv ====
// Sample stream source standing in for the ADC path ahead of the volume stage.
`timescale 1ns/1ns
`default_nettype none
module ivl_adc_model
  import ivl_pkg::*;
#(
  parameter int PERIOD = 4
)
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [15:0] amp_i,
  input wire logic toggle_i,
  output ivl_sample_t level_o
);
  int cnt;
  logic neg;
  logic [15:0] val;
  assign val = neg ? (~amp_i + 16'h0001) : amp_i;
  // Off the strobe the data is inverted so a design that samples it late sees nonsense.
  always_comb begin
    level_o.valid = rstn_i && (cnt == PERIOD - 1);
    level_o.left = level_o.valid ? val : ~val;
    level_o.right = level_o.valid ? val : ~val;
  end
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      neg <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (level_o.valid && toggle_i) begin
        neg <= !neg;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the input volume and level control block.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ivl_pkg::*;
;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  ivl_wr_t wr_i = '0;
  logic [7:0] rd_addr_i = 8'h00;
  ivl_cfg_t cfg_i = '0;
  logic pwr_l = 1'b0;
  logic pwr_r = 1'b0;
  logic [15:0] amp = 16'h0100;
  logic toggle = 1'b1;
  ivl_sample_t level;
  logic [7:0] rd_data_o;
  logic [7:0] left_gain_o;
  logic [7:0] right_gain_o;
  logic active;
  logic fast;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  ivl_adc_model #(.PERIOD(4)) i_adc (.clock_i(clock_i), .rstn_i(rstn_i), .amp_i(amp),
    .toggle_i(toggle), .level_o(level));
  ivl_volume_ctrl i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .wr_i(wr_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .cfg_i(cfg_i),
    .left_adc_power_i(pwr_l), .right_adc_power_i(pwr_r), .level_i(level),
    .left_gain_o(left_gain_o), .right_gain_o(right_gain_o),
    .level_control_active_o(active), .fast_recovery_o(fast));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The ceiling sits well above the few thousand cycles the sequence needs.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= '{en: 1'b1, addr: a, data: d};
    @(posedge clock_i);
    wr_i.en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    rd_addr_i <= a;
    repeat (2) @(posedge clock_i);
    #1 chk(rd_data_o, exp);
  endtask

  task automatic wait_gain(input logic [7:0] el, input logic [7:0] er, input int lim);
    for (int i = 0; i < lim && !(left_gain_o === el && right_gain_o === er); i++) begin
      @(posedge clock_i);
      #1;
    end
    chk(left_gain_o, el);
    chk(right_gain_o, er);
  endtask

  task automatic t_reset();
    rd(ADDR_LEFT_GAIN, GAIN_RESET);
    rd(ADDR_RIGHT_GAIN, GAIN_RESET);
    rd(8'h0a, READ_ZERO);
    chk(left_gain_o, GAIN_RESET);
    $display("test reset done");
  endtask

  task automatic t_power_up();
    wr(ADDR_LEFT_GAIN, 8'h91);
    rd(ADDR_LEFT_GAIN, 8'h91);
    @(posedge clock_i);
    pwr_l <= 1'b1;
    repeat (200) @(posedge clock_i);
    #1 chk(left_gain_o, GAIN_RESET);
    wait_gain(8'h91, GAIN_RESET, 120);
    $display("test power up done");
  endtask

  task automatic t_manual_timeout();
    toggle <= 1'b0;
    // Let the last sign change pass, so only the timeout can apply the new codes.
    repeat (8) @(posedge clock_i);
    wr(ADDR_LEFT_GAIN, 8'h92);
    wr(ADDR_RIGHT_GAIN, 8'h30);
    repeat (400) @(posedge clock_i);
    #1 chk(right_gain_o, GAIN_RESET);
    chk(left_gain_o, 8'h91);
    wait_gain(8'h92, 8'h30, 160);
    // The repeated write lands on a sample strobe, where a restart would show.
    repeat (2) @(posedge clock_i);
    wr(ADDR_RIGHT_GAIN, 8'h30);
    rd(ADDR_RIGHT_GAIN, 8'h30);
    wr(ADDR_LEFT_GAIN, 8'h91);
    rd(ADDR_LEFT_GAIN, 8'h91);
    toggle <= 1'b1;
    $display("test manual timeout done");
  endtask

  task automatic t_enable();
    @(posedge clock_i);
    cfg_i.recovery_step_sel <= 2'h1;
    cfg_i.recovery_ceiling_gain <= 8'h93;
    cfg_i.limiter_zero_cross_disable <= 1'b1;
    @(posedge clock_i);
    cfg_i.level_control_enable <= 1'b1;
    wait_gain(8'h91, 8'h91, 8);
    chk({7'h00, active}, 8'h01);
    wr(ADDR_LEFT_GAIN, 8'h20);
    rd(ADDR_LEFT_GAIN, 8'h91);
    $display("test enable done");
  endtask

  task automatic t_recovery();
    wait_gain(8'h93, 8'h93, 700);
    repeat (1100) @(posedge clock_i);
    #1 chk(left_gain_o, 8'h93);
    $display("test recovery done");
  endtask

  task automatic t_limiter();
    amp <= 16'h6000;
    wait_gain(8'h92, 8'h92, 12);
    wait_gain(8'h91, 8'h91, 6);
    amp <= 16'h4fd5;
    repeat (600) @(posedge clock_i);
    #1 chk(left_gain_o, 8'h91);
    amp <= 16'h0100;
    $display("test limiter done");
  endtask

  task automatic t_disable();
    @(posedge clock_i);
    cfg_i.level_control_enable <= 1'b0;
    wait_gain(8'h91, 8'h30, 700);
    chk({7'h00, active}, 8'h00);
    $display("test disable done");
  endtask

  task automatic t_fast();
    repeat (520) @(posedge clock_i);
    cfg_i.limiter_threshold_sel <= 2'h1;
    cfg_i.limiter_step_sel <= 2'h1;
    cfg_i.recovery_wait_sel <= 3'h2;
    cfg_i.fast_recovery_speed_sel <= 2'h1;
    cfg_i.limiter_zero_cross_disable <= 1'b0;
    @(posedge clock_i);
    cfg_i.level_control_enable <= 1'b1;
    wait_gain(8'h91, 8'h91, 8);
    amp <= 16'h5000;
    wait_gain(8'h8f, 8'h8f, 12);
    chk({7'h00, fast}, 8'h00);
    amp <= 16'h7f00;
    wait_gain(8'h8d, 8'h8d, 12);
    amp <= 16'h0100;
    chk({7'h00, fast}, 8'h01);
    // A normal wait here would take about 2050 cycles, so the limit catches a slow step.
    wait_gain(8'h8f, 8'h8f, 320);
    chk({7'h00, fast}, 8'h00);
    $display("test fast recovery done");
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset();
    t_power_up();
    t_manual_timeout();
    t_enable();
    t_recovery();
    t_limiter();
    t_disable();
    t_fast();
    summarize();
  end
endmodule
`default_nettype wire
